// ---- sac_avg_ctrl.sv ----
// Averaging control, per-bin store and display gating of the analyzer.
// Assumes an APB master on sys_clk_i and a sample stream from the transform.
//
// Behaviour
// - Peak mode keeps the largest amplitude per bin.
// - Peak mode stores the phase that came with the held maximum.
// - Count limit is a power of two from 4 up to 256.
// - Shift picks the lower or upper bank of count values.
// - Exponential update is quarter new plus three quarters old.
// - Exponential weights RMS, and with peak gives endless peak hold.
// - Counted modes stop taking data at the limit and hold.
// - Restart after completion begins a fresh sequence.
// - Any mode change except toggling exponential update restarts the sequence by itself.
// - Raising the limit resumes from the current count, no restart.
// - RMS sums squared amplitudes and phases over m spectra.
// - Time average sums successive records sample by sample.
// - Time display overrides and suspends all other displays.
// - One time display at most, only while its button is held.
// - Baseband time display shows every second stored sample.
// - Coherence shows only with both channels, RMS and its select.
// - Coherence is valid once the RMS sequence reaches its count.
// - Enabling RMS with a count starts accumulating at once.
// - Coherence is scaled so that one means ideal causality.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_avg_ctrl
	import sac_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sac_pkg::sac_sample_t smp_i,
	output logic smp_ready_o,
	input wire logic [`SAC_BIN_AW-1:0] rd_bin_i,
	output sac_pkg::sac_acc_t rd_data_o,
	input wire logic baseband_i,
	output logic [`SAC_BIN_AW-1:0] time_idx_o,
	output logic [1:0] time_disp_o,
	output logic spec_disp_en_o,
	output logic coherence_display_select_o,
	output logic coherence_display_select_valid_o,
	output logic [15:0] coherence_display_select_unity_o,
	output logic done_o
);
	import sac_pkg::*;

	typedef enum {ST_RUN, ST_HOLD} sac_state_t;

	logic [31:0] ctrl_r;
	logic [31:0] disp_r;
	logic restart_req;
	logic [8:0] count_r;
	logic [8:0] limit;
	logic [3:0] lg;
	logic done_r;
	sac_state_t state_r;
	sac_mode_t mode;
	sac_mode_t mode_q_r;
	logic exp_mode;
	logic mode_chg;
	logic accept;
	logic counted;
	logic ta_s1_r, ta_s2_r, ta_s3_r, ta_r;
	logic tb_s1_r, tb_s2_r, tb_s3_r, tb_r;
	logic [`SAC_BIN_AW-1:0] tidx_r;
	sac_acc_t mem [0:`SAC_BINS-1];
	sac_acc_t acc_new;
	logic wr_en;
	logic rd_en;

	assign mode = sac_mode_t'(ctrl_r[`SAC_CTRL_MODE_LSB +: 2]);
	assign exp_mode = ctrl_r[`SAC_CTRL_EXP_BIT];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign pready = 1'b1;
	assign restart_req = wr_en && (paddr == `SAC_OFF_RSTRT);

	always_comb
	begin
		lg = `SAC_MIN_LOG2 + {2'b00, ctrl_r[`SAC_CTRL_SEL_LSB +: 2]};
		if (ctrl_r[`SAC_CTRL_SHIFT_BIT])
			lg = lg + `SAC_BANK_SPAN;
		if (lg > `SAC_MAX_LOG2)
			lg = `SAC_MAX_LOG2;
		limit = 9'h001 << lg;
	end

	assign mode_chg = (mode != mode_q_r);
	assign counted = (mode != SAC_OFF) && !exp_mode;
	assign smp_ready_o = (mode != SAC_OFF) && (state_r == ST_RUN)
		&& !mode_chg && !restart_req;
	assign accept = smp_i.valid && smp_ready_o;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pslverr <= 1'b0;
			if (rd_en && !penable)
			begin
				if (paddr == `SAC_OFF_CTRL)
					prdata <= ctrl_r;
				else if (paddr == `SAC_OFF_DISP)
					prdata <= disp_r;
				else if (paddr == `SAC_OFF_STAT)
					prdata <= {22'h0, done_r, count_r};
				else if (paddr == `SAC_OFF_RSTRT)
					prdata <= 32'h0000_0000;
				else
				begin
					prdata <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			end
			else if (psel && !penable && pwrite
				&& paddr != `SAC_OFF_CTRL && paddr != `SAC_OFF_DISP
				&& paddr != `SAC_OFF_RSTRT)
				pslverr <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_r <= `SAC_CTRL_RST;
			disp_r <= `SAC_DISP_RST;
		end
		else if (wr_en && paddr == `SAC_OFF_CTRL)
			ctrl_r <= {24'h0, pwdata[7:0]};
		else if (wr_en && paddr == `SAC_OFF_DISP)
			disp_r <= {28'h0, pwdata[3:0]};
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mode_q_r <= SAC_OFF;
		else
			mode_q_r <= mode;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_r <= 9'h000;
			state_r <= ST_RUN;
			done_r <= 1'b0;
		end
		else if (mode_chg || restart_req || mode == SAC_OFF)
		begin
			count_r <= 9'h000;
			state_r <= ST_RUN;
			done_r <= 1'b0;
		end
		else
		begin
			case (state_r)
			ST_RUN:
			begin
				if (accept && smp_i.bin == {`SAC_BIN_AW{1'b1}}
					&& count_r < limit)
					count_r <= count_r + 9'h001;
				if (counted && count_r >= limit)
				begin
					state_r <= ST_HOLD;
					done_r <= 1'b1;
				end
			end
			ST_HOLD:
			begin
				if (count_r < limit || !counted)
				begin
					state_r <= ST_RUN;
					done_r <= 1'b0;
				end
			end
			default:
				state_r <= ST_RUN;
			endcase
		end
	end

	sac_bin_math u_math (
		.mode_i(mode),
		.exp_i(exp_mode),
		.first_i(count_r == 9'h000),
		.smp_i(smp_i),
		.old_i(mem[smp_i.bin]),
		.new_o(acc_new)
	);

	// The store has no reset; the first spectrum overwrites every bin.
	always_ff @(posedge sys_clk_i)
	begin
		if (accept)
			mem[smp_i.bin] <= acc_new;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_data_o <= '0;
		else
			rd_data_o <= mem[rd_bin_i];
	end

	// The time buttons are filtered like panel pins, so a press shows late.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{ta_s1_r, ta_s2_r, ta_s3_r, ta_r} <= 4'h0;
			{tb_s1_r, tb_s2_r, tb_s3_r, tb_r} <= 4'h0;
		end
		else
		begin
			ta_s1_r <= disp_r[`SAC_DISP_TIMEA_BIT];
			ta_s2_r <= ta_s1_r;
			ta_s3_r <= ta_s2_r;
			tb_s1_r <= disp_r[`SAC_DISP_TIMEB_BIT];
			tb_s2_r <= tb_s1_r;
			tb_s3_r <= tb_s2_r;
			if (ta_s2_r == ta_s3_r)
				ta_r <= ta_s3_r;
			if (tb_s2_r == tb_s3_r)
				tb_r <= tb_s3_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			time_disp_o <= 2'h0;
			tidx_r <= '0;
		end
		else
		begin
			if (ta_r)
				time_disp_o <= 2'h1;
			else if (tb_r)
				time_disp_o <= 2'h2;
			else
				time_disp_o <= 2'h0;
			if (time_disp_o != 2'h0)
				tidx_r <= tidx_r + (baseband_i ? `SAC_BIN_AW'(2)
					: `SAC_BIN_AW'(1));
			else
				tidx_r <= '0;
		end
	end

	assign time_idx_o = tidx_r;
	assign spec_disp_en_o = (time_disp_o == 2'h0);
	assign coherence_display_select_o = spec_disp_en_o
		&& disp_r[`SAC_DISP_COHERENCE_DISPLAY_SELECT_BIT] && disp_r[`SAC_DISP_BOTH_BIT]
		&& (mode == SAC_RMS);
	assign coherence_display_select_valid_o = coherence_display_select_o && done_r
		&& (count_r >= limit);
	assign coherence_display_select_unity_o = 16'h8000;
	assign done_o = done_r;

	property p_stop;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		done_r |-> !smp_ready_o;
	endproperty
	a_stop: assert property (p_stop) else $error("data taken at hold");

	property p_mode_restart;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		mode_chg |=> (count_r == 9'h000) && !done_r;
	endproperty
	a_mode_restart: assert property (p_mode_restart)
		else $error("mode change kept count");

	property p_restart;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		restart_req |=> count_r == 9'h000;
	endproperty
	a_restart: assert property (p_restart) else $error("restart missed");

	property p_coherence_display_select;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		coherence_display_select_o |-> mode == SAC_RMS
			&& disp_r[`SAC_DISP_BOTH_BIT];
	endproperty
	a_coherence_display_select: assert property (p_coherence_display_select) else $error("coherence ungated");

	property p_cvalid;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		coherence_display_select_valid_o |-> count_r >= limit;
	endproperty
	a_cvalid: assert property (p_cvalid) else $error("coherence early");

	property p_time;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(time_disp_o != 2'h3) && (time_disp_o == 2'h0 || !spec_disp_en_o);
	endproperty
	a_time: assert property (p_time) else $error("time display clash");

	property p_exp;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		exp_mode && $past(exp_mode) && !mode_chg && !$past(mode_chg)
			|-> !done_r;
	endproperty
	a_exp: assert property (p_exp) else $error("exp mode stopped");

	property p_count;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		count_r <= limit || $past(count_r) >= $past(limit);
	endproperty
	a_count: assert property (p_count) else $error("count past limit");

	property p_resume;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		state_r == ST_HOLD && count_r < limit && !mode_chg && !restart_req
			&& mode != SAC_OFF |=> state_r == ST_RUN
			&& count_r == $past(count_r);
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");
endmodule

// ---- sac_avg_ctrl_test.sv ----
// Self-checking bench for the averager, driven over APB and a sample stream.
// Assumes the transform model and the design files are compiled first.
`timescale 1ns/1ps
`include "sac_map.svh"
`define CHK(nm, e, g) \
	n_tests++; \
	if ((g) !== (e)) \
	begin \
		$display("wrong value %s exp %0h got %0h", nm, e, g); \
		bad_count++; \
	end
module sac_avg_ctrl_test;
	import sac_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	sac_sample_t smp;
	logic ready;
	logic [5:0] rd_bin = 6'h00;
	sac_acc_t rd_data;
	logic [5:0] tidx;
	logic [1:0] tdisp;
	logic spec_en, coh_sel, coh_val, done, busy;
	logic [15:0] unity;
	logic start = 1'b0;
	logic [15:0] amp = 16'h0;
	logic [15:0] ph = 16'h0;
	logic [31:0] rd;
	logic err;
	logic bband = 1'b0;
	int bad_count = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	sac_avg_ctrl i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_i(smp),
		.smp_ready_o(ready), .rd_bin_i(rd_bin), .rd_data_o(rd_data),
		.baseband_i(bband), .time_idx_o(tidx), .time_disp_o(tdisp),
		.spec_disp_en_o(spec_en), .coherence_display_select_o(coh_sel),
		.coherence_display_select_valid_o(coh_val), .coherence_display_select_unity_o(unity), .done_o(done));
	sac_src_model i_src (.sys_clk_i(clk), .rst_n_i(rst_n), .start_i(start),
		.amp_i(amp), .phase_i(ph), .ready_i(ready), .smp_o(smp),
		.busy_o(busy));
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("reg", e, rd)
	endtask
	// Waiting on the model bounds any stall of the averager.
	task automatic spec(input logic [15:0] a, input logic [15:0] p);
		int n;
		@(posedge clk);
		amp <= a;
		ph <= p;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 300);
		if (n >= 300)
		begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic rbin(input logic [5:0] b, input logic [63:0] e);
		@(posedge clk);
		rd_bin <= b;
		@(posedge clk);
		@(posedge clk);
		`CHK("bin", e, rd_data)
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rchk(`SAC_OFF_CTRL, `SAC_CTRL_RST);
		apb(1'b0, 12'h010, 32'h0);
		`CHK("err", 1'b1, err)
		`CHK("unity", 16'h8000, unity)
		`CHK("pready", 1'b1, pready)
		apb(1'b1, `SAC_OFF_DISP, 32'h3);
		rchk(`SAC_OFF_DISP, 32'h3);
		apb(1'b1, `SAC_OFF_CTRL, 32'h1);
		spec(16'h1, 16'h1);
		`CHK("cval", 1'b0, coh_val)
		spec(16'h2, 16'h2);
		spec(16'h3, 16'h3);
		spec(16'h4, 16'h4);
		rchk(`SAC_OFF_STAT, 32'h204);
		`CHK("rdy", 1'b0, ready)
		`CHK("cval", 1'b1, coh_val)
		`CHK("csel", 1'b1, coh_sel)
		rbin(6'h05, {32'd30, 32'd10});
		apb(1'b1, `SAC_OFF_CTRL, 32'h11);
		rchk(`SAC_OFF_STAT, 32'h004);
		repeat (4) spec(16'h1, 16'h0);
		rchk(`SAC_OFF_STAT, 32'h208);
		rbin(6'h3F, {32'd34, 32'd10});
		apb(1'b1, `SAC_OFF_RSTRT, 32'h0);
		rchk(`SAC_OFF_STAT, 32'h0);
		apb(1'b1, `SAC_OFF_CTRL, 32'h9);
		repeat (63) spec(16'h0, 16'h0);
		rchk(`SAC_OFF_STAT, 32'h03F);
		spec(16'h0, 16'h0);
		rchk(`SAC_OFF_STAT, 32'h240);
		apb(1'b1, `SAC_OFF_CTRL, 32'h3);
		rchk(`SAC_OFF_STAT, 32'h0);
		spec(16'h5, 16'h1);
		spec(16'h9, 16'h2);
		spec(16'h3, 16'h3);
		rbin(6'h07, {32'h9, 32'h2});
		`CHK("csel", 1'b0, coh_sel)
		apb(1'b1, `SAC_OFF_CTRL, 32'h7);
		repeat (5) spec(16'h1, 16'h1);
		@(posedge clk);
		`CHK("done", 1'b0, done)
		apb(1'b1, `SAC_OFF_CTRL, 32'h2);
		spec(16'h3, 16'h1);
		spec(16'h4, 16'h1);
		rbin(6'h10, {32'd7, 32'd2});
		apb(1'b1, `SAC_OFF_CTRL, 32'h5);
		spec(16'h2, 16'h0);
		spec(16'h4, 16'h0);
		rbin(6'h20, {32'd7, 32'd0});
		bband <= 1'b1;
		apb(1'b1, `SAC_OFF_DISP, 32'hF);
		repeat (6) @(posedge clk);
		`CHK("tdisp", 2'h1, tdisp)
		`CHK("spec", 1'b0, spec_en)
		@(posedge clk);
		`CHK("tidx", 6'h02, tidx)
		bband <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("tidx", 6'h05, tidx)
		apb(1'b1, `SAC_OFF_DISP, 32'h0);
		repeat (6) @(posedge clk);
		`CHK("tdisp", 2'h0, tdisp)
		`CHK("spec", 1'b1, spec_en)
		close_out();
	end
endmodule

// ---- sac_bin_math.sv ----
// Per-bin combine step for one incoming sample against its stored state.
// Assumes the caller supplies the stored state of the same bin.
`timescale 1ns/1ps
module sac_bin_math
	import sac_pkg::*;
(
	input wire sac_pkg::sac_mode_t mode_i,
	input wire logic exp_i,
	input wire logic first_i,
	input wire sac_pkg::sac_sample_t smp_i,
	input wire sac_pkg::sac_acc_t old_i,
	output sac_pkg::sac_acc_t new_o
);
	logic [31:0] sq;
	logic [31:0] amp_w;
	logic [31:0] ph_w;
	always_comb
	begin
		sq = 32'(smp_i.amp) * 32'(smp_i.amp);
		amp_w = (mode_i == SAC_RMS) ? sq : 32'(smp_i.amp);
		ph_w = 32'(smp_i.phase);
		new_o = old_i;
		if (first_i)
		begin
			new_o.acc_amp = amp_w;
			new_o.acc_phase = ph_w;
		end
		else if (mode_i == SAC_PEAK)
		begin
			if (amp_w > old_i.acc_amp)
			begin
				new_o.acc_amp = amp_w;
				new_o.acc_phase = ph_w;
			end
		end
		else if (exp_i)
		begin
			new_o.acc_amp = (amp_w >> 2) + old_i.acc_amp
				- (old_i.acc_amp >> 2);
			new_o.acc_phase = (ph_w >> 2) + old_i.acc_phase
				- (old_i.acc_phase >> 2);
		end
		else
		begin
			new_o.acc_amp = old_i.acc_amp + amp_w;
			new_o.acc_phase = old_i.acc_phase + ph_w;
		end
	end
endmodule

// ---- sac_map.svh ----
// Register offsets, field positions, reset values and counts of the averager.
// Assumes inclusion by the package, the averager and its test bench.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_DISP 12'h004
`define SAC_OFF_STAT 12'h008
`define SAC_OFF_RSTRT 12'h00C
`define SAC_CTRL_MODE_LSB 0
`define SAC_CTRL_EXP_BIT 2
`define SAC_CTRL_SHIFT_BIT 3
`define SAC_CTRL_SEL_LSB 4
`define SAC_DISP_COHERENCE_DISPLAY_SELECT_BIT 0
`define SAC_DISP_BOTH_BIT 1
`define SAC_DISP_TIMEA_BIT 2
`define SAC_DISP_TIMEB_BIT 3
`define SAC_CTRL_RST 32'h0000_0000
`define SAC_DISP_RST 32'h0000_0000
`define SAC_MIN_LOG2 4'h2
`define SAC_BANK_SPAN 4'h4
`define SAC_MAX_LOG2 4'h8
`define SAC_BINS 64
`define SAC_BIN_AW 6
`endif

// ---- sac_pkg.sv ----
// Types shared by the averager and its per-bin arithmetic.
// Assumes the constants header is reachable by bare name.
`include "sac_map.svh"
package sac_pkg;
	typedef enum logic [1:0] {SAC_OFF, SAC_RMS, SAC_TIME, SAC_PEAK} sac_mode_t;
	typedef struct packed {
		logic valid;
		logic first;
		logic [`SAC_BIN_AW-1:0] bin;
		logic [15:0] amp;
		logic [15:0] phase;
	} sac_sample_t;
	typedef struct packed {
		logic [31:0] acc_amp;
		logic [31:0] acc_phase;
	} sac_acc_t;
endpackage

// ---- sac_src_model.sv ----
// Behavioural transform stage streaming one 64-bin spectrum per start.
// Assumes the averager's valid and ready handshake on the same clock.
`timescale 1ns/1ps
module sac_src_model
	import sac_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [15:0] amp_i,
	input wire logic [15:0] phase_i,
	input wire logic ready_i,
	output sac_pkg::sac_sample_t smp_o,
	output logic busy_o
);
	// Released lines show the inverse of the last sample, never stale data.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			smp_o <= '0;
			busy_o <= 1'b0;
		end
		else if (start_i && !busy_o)
		begin
			busy_o <= 1'b1;
			smp_o <= {1'b1, 1'b1, 6'h00, amp_i, phase_i};
		end
		else if (smp_o.valid && ready_i)
		begin
			if (smp_o.bin == 6'h3F)
			begin
				busy_o <= 1'b0;
				smp_o <= ~smp_o;
			end
			else
			begin
				smp_o.bin <= smp_o.bin + 6'h01;
				smp_o.first <= 1'b0;
			end
		end
	end
endmodule
